// *** rtl/embi_pkg.sv ***
package embi_pkg;
   localparam int ADDR_W = 27;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int BANKS = 8;
   localparam int BANK_IDX_W = 3;
   localparam int CYC_W = 4;
   localparam int SIZE_SEL_W = 3;
   localparam int SIZE_BASE_LOG2 = 20;
   localparam int REQ_ADDR_W = 30;
   localparam int BEAT_W = 2;
   localparam int DRAM_SEL_W = 2;
   localparam int DRAM_CLK_W = 2;

   localparam logic [1:0] BOOT_NAND = 2'h0;
   localparam logic [1:0] BOOT_W16 = 2'h1;
   localparam logic [1:0] BOOT_W32 = 2'h2;
   localparam logic [1:0] BOOT_TEST = 2'h3;

   localparam logic [1:0] WID_8 = 2'h0;
   localparam logic [1:0] WID_16 = 2'h1;
   localparam logic [1:0] WID_32 = 2'h2;
   localparam logic [1:0] BANK0_NAND_WIDTH = WID_16;

   localparam logic [CYC_W-1:0] CYC_MIN = 4'h1;
   localparam logic [7:0] BANK_NONE_N = 8'hFF;
   localparam logic [3:0] LANES_OFF_N = 4'hF;
   localparam logic [1:0] BOOT_RESET = BOOT_W16;

   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_STROBE = 5'h02,
      ST_WAIT = 5'h04,
      ST_NEXT = 5'h08,
      ST_HOLD = 5'h10
   } embi_state_e;

   typedef struct packed
   {
      logic we;
      logic [REQ_ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [LANES-1:0] be;
   } embi_req_s;

   typedef struct packed
   {
      logic [DATA_W-1:0] rdata;
      logic err;
   } embi_rsp_s;
endpackage : embi_pkg

// *** rtl/embi_sync.sv ***
`timescale 1ns/1ps
module embi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   // First stage feeds only the second stage
   always_comb
   begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         meta_ff <= INIT;
         sync_ff <= INIT;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;
endmodule : embi_sync

// *** rtl/embi_ctrl.sv ***
`timescale 1ns/1ps
//Contract
// - Boot pins: NAND, 16-bit, 32-bit, test
// - Boot pins captured while reset held
// - 27-bit address bus for bank
// - Sample data on reads, drive writes
// - Bus width 8, 16 or 32 bits
// - Bank select by region; programmable cycles, size
// - Write strobe low marks write cycle
// - Read strobe low marks read cycle
// - External master requests bus via hold request
// - Acknowledge only after bus surrendered
// - Cycle cannot end while wait low; code sees wait two cycles late, missing a fall in the last two strobe cycles
// - Four lane enables, four write byte enables
// - DRAM strobes, selects, masks, clocks, enable
// - Shared pins released while other master holds
module embi_ctrl (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] boot_mode_pins_i,
   input wire logic [embi_pkg::CYC_W*embi_pkg::BANKS-1:0] bank_cycles_i,
   input wire logic [2*embi_pkg::BANKS-1:0] bank_width_i,
   input wire logic [embi_pkg::SIZE_SEL_W*embi_pkg::BANKS-1:0] bank_size_i,
   input wire logic req_valid_i,
   input wire embi_pkg::embi_req_s req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output embi_pkg::embi_rsp_s rsp_o,
   output logic nand_boot_o,
   output logic test_mode_o,
   output logic [embi_pkg::ADDR_W-1:0] addr_o,
   output logic [embi_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [embi_pkg::DATA_W-1:0] data_i,
   output logic bus_oe_o,
   output logic [embi_pkg::BANKS-1:0] bank_select_n_o,
   output logic write_strobe_n_o,
   output logic read_strobe_n_o,
   output logic [embi_pkg::LANES-1:0] byte_lane_enable_n_o,
   output logic [embi_pkg::LANES-1:0] write_byte_enable_n_o,
   input wire logic cycle_extend_n_i,
   input wire logic bus_hold_request_n_i,
   output logic bus_hold_ack_n_o,
   output logic dram_row_strobe_n_o,
   output logic dram_col_strobe_n_o,
   output logic [embi_pkg::DRAM_SEL_W-1:0] dram_select_n_o,
   output logic [embi_pkg::LANES-1:0] dram_mask_o,
   output logic [embi_pkg::DRAM_CLK_W-1:0] dram_clk_o,
   output logic dram_clock_enable_o
);
   logic [1:0] boot_sync;
   logic wait_n_sync;
   logic hold_n_sync;
   logic [embi_pkg::DATA_W-1:0] data_sync;

   embi_sync #(.WIDTH(2), .INIT(embi_pkg::BOOT_RESET)) u_boot_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(1'b1),
      .async_i(boot_mode_pins_i),
      .sync_o(boot_sync)
   );

   embi_sync #(.WIDTH(2), .INIT(2'h3)) u_ctl_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({cycle_extend_n_i, bus_hold_request_n_i}),
      .sync_o({wait_n_sync, hold_n_sync})
   );

   embi_sync #(.WIDTH(embi_pkg::DATA_W)) u_data_sync (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .async_i(data_i),
      .sync_o(data_sync)
   );

   // Boot strap state
   logic [1:0] boot_ff;
   logic [1:0] nxt_boot;
   logic nand_boot_ff;
   logic nxt_nand_boot;
   logic test_mode_ff;
   logic nxt_test_mode;

   // Latched while reset is low so the last sampled level wins at release
   always_comb
   begin
      nxt_boot = rst_n_i ? boot_ff : boot_sync;
      nxt_nand_boot = (nxt_boot == embi_pkg::BOOT_NAND);
      nxt_test_mode = (nxt_boot == embi_pkg::BOOT_TEST);
   end

   always_ff @(posedge sys_clk_i)
   begin
      boot_ff <= nxt_boot;
      nand_boot_ff <= nxt_nand_boot;
      test_mode_ff <= nxt_test_mode;
   end

   // Effective width of each bank; bank 0 follows the straps
   logic [1:0] width_of [embi_pkg::BANKS];
   genvar gi;
   generate
      for (gi = 0; gi < embi_pkg::BANKS; gi++)
      begin : g_width
         if (gi == 0)
         begin : g_bank0
            assign width_of[gi] = (boot_ff == embi_pkg::BOOT_W32) ? embi_pkg::WID_32 :
                                  (boot_ff == embi_pkg::BOOT_W16) ? embi_pkg::WID_16 :
                                  embi_pkg::BANK0_NAND_WIDTH;
         end
         else
         begin : g_bankn
            assign width_of[gi] = bank_width_i[2*gi +: 2];
         end
      end
   endgenerate

   // Bus cycle state
   embi_pkg::embi_state_e state_ff, nxt_state;
   embi_pkg::embi_req_s req_ff, nxt_req;
   logic [1:0] wid_ff, nxt_wid;
   logic [embi_pkg::CYC_W-1:0] cyc_ff, nxt_cyc;
   logic [embi_pkg::CYC_W-1:0] cyc_load_ff, nxt_cyc_load;
   logic [embi_pkg::BEAT_W-1:0] beat_ff, nxt_beat;
   logic [embi_pkg::BANKS-1:0] sel_n_ff, nxt_sel_n;
   logic [embi_pkg::BANKS-1:0] hit_sel_n_ff, nxt_hit_sel_n;
   logic [embi_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
   logic [embi_pkg::DATA_W-1:0] dout_ff, nxt_dout;
   logic [embi_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
   logic dout_oe_ff, nxt_dout_oe;
   logic bus_oe_ff, nxt_bus_oe;
   logic wr_n_ff, nxt_wr_n;
   logic rd_n_ff, nxt_rd_n;
   logic [embi_pkg::LANES-1:0] lane_n_ff, nxt_lane_n;
   logic [embi_pkg::LANES-1:0] wbe_n_ff, nxt_wbe_n;
   logic ack_n_ff, nxt_ack_n;
   logic ready_ff, nxt_ready;
   logic rsp_valid_ff, nxt_rsp_valid;
   embi_pkg::embi_rsp_s rsp_ff, nxt_rsp;
   logic [embi_pkg::DRAM_CLK_W-1:0] dclk_ff, nxt_dclk;
   logic dcke_ff, nxt_dcke;

   logic [embi_pkg::BANK_IDX_W-1:0] req_bank;
   logic [embi_pkg::SIZE_SEL_W-1:0] req_size;
   logic [embi_pkg::ADDR_W-1:0] req_off;
   logic [embi_pkg::ADDR_W-1:0] size_mask;
   logic in_region;
   logic [embi_pkg::BEAT_W-1:0] last_beat;
   logic [embi_pkg::BEAT_W-1:0] beat_sel;
   logic [embi_pkg::ADDR_W-1:0] beat_addr;
   logic [embi_pkg::DATA_W-1:0] beat_dout;
   logic [embi_pkg::LANES-1:0] beat_lane;
   logic [embi_pkg::CYC_W-1:0] req_cyc;

   // Region decode
   always_comb
   begin
      req_bank = req_i.addr[embi_pkg::REQ_ADDR_W-1 -: embi_pkg::BANK_IDX_W];
      req_off = req_i.addr[embi_pkg::ADDR_W-1:0];
      req_size = bank_size_i[embi_pkg::SIZE_SEL_W*req_bank +: embi_pkg::SIZE_SEL_W];
      size_mask = ~((embi_pkg::ADDR_W'(1) << (embi_pkg::SIZE_BASE_LOG2 + int'(req_size))) -
                    embi_pkg::ADDR_W'(1));
      in_region = ((req_off & size_mask) == '0);
      req_cyc = bank_cycles_i[embi_pkg::CYC_W*req_bank +: embi_pkg::CYC_W];
      if (req_cyc < embi_pkg::CYC_MIN)
      begin
         req_cyc = embi_pkg::CYC_MIN;
      end
   end

   // Last beat from the registered width keeps the beat logic loop-free
   assign last_beat = (wid_ff == embi_pkg::WID_8) ? 2'h3 :
                      (wid_ff == embi_pkg::WID_16) ? 2'h1 : 2'h0;

   // Beat placement for the programmed width
   always_comb
   begin
      beat_sel = (state_ff == embi_pkg::ST_IDLE) ? '0 : nxt_beat;
      case (nxt_wid)
         embi_pkg::WID_8:
         begin
            beat_addr = {nxt_req.addr[embi_pkg::ADDR_W-1:2], beat_sel};
            beat_dout = {24'h000000, nxt_req.wdata[8*beat_sel +: 8]};
            beat_lane = {3'h0, nxt_req.be[beat_sel]};
         end
         embi_pkg::WID_16:
         begin
            beat_addr = {nxt_req.addr[embi_pkg::ADDR_W-1:2], beat_sel[0], 1'b0};
            beat_dout = {16'h0000, nxt_req.wdata[16*beat_sel[0] +: 16]};
            beat_lane = {2'h0, nxt_req.be[2*beat_sel[0] +: 2]};
         end
         default:
         begin
            beat_addr = {nxt_req.addr[embi_pkg::ADDR_W-1:2], 2'h0};
            beat_dout = nxt_req.wdata;
            beat_lane = nxt_req.be;
         end
      endcase
   end

   // Next values of the bus cycle
   always_comb
   begin
      nxt_state = state_ff;
      nxt_req = req_ff;
      nxt_wid = wid_ff;
      nxt_cyc = cyc_ff;
      nxt_cyc_load = cyc_load_ff;
      nxt_beat = beat_ff;
      nxt_hit_sel_n = hit_sel_n_ff;
      nxt_rdata = rdata_ff;
      nxt_bus_oe = bus_oe_ff;
      nxt_ack_n = ack_n_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rsp = rsp_ff;
      nxt_dclk = ~dclk_ff;
      nxt_dcke = 1'b1;
      case (state_ff)
         embi_pkg::ST_IDLE:
         begin
            nxt_bus_oe = ack_n_ff;
            // A request already shown ready wins over a fresh hold
            if (req_valid_i && ready_ff)
            begin
               nxt_req = req_i;
               nxt_wid = width_of[req_bank];
               nxt_beat = '0;
               nxt_rdata = '0;
               nxt_cyc = req_cyc;
               nxt_cyc_load = req_cyc;
               if (in_region)
               begin
                  nxt_hit_sel_n = ~(embi_pkg::BANKS'(1) << req_bank);
                  nxt_state = embi_pkg::ST_STROBE;
               end
               else
               begin
                  // Out-of-region access ends at once, no pin activity
                  nxt_rsp_valid = 1'b1;
                  nxt_rsp = '{rdata: '0, err: 1'b1};
               end
            end
            else if (!hold_n_sync)
            begin
               nxt_bus_oe = 1'b0;
               nxt_state = embi_pkg::ST_HOLD;
            end
         end
         embi_pkg::ST_STROBE:
         begin
            nxt_cyc = cyc_ff - embi_pkg::CYC_W'(1);
            if (cyc_ff == embi_pkg::CYC_MIN)
            begin
               nxt_state = embi_pkg::ST_WAIT;
            end
         end
         embi_pkg::ST_WAIT:
         begin
            if (wait_n_sync)
            begin
               case (wid_ff)
                  embi_pkg::WID_8:
                     nxt_rdata[8*beat_ff +: 8] = data_sync[7:0];
                  embi_pkg::WID_16:
                     nxt_rdata[16*beat_ff[0] +: 16] = data_sync[15:0];
                  default:
                     nxt_rdata = data_sync;
               endcase
               nxt_state = embi_pkg::ST_NEXT;
            end
         end
         embi_pkg::ST_NEXT:
         begin
            if (beat_ff == last_beat)
            begin
               nxt_rsp_valid = 1'b1;
               nxt_rsp = '{rdata: rdata_ff, err: 1'b0};
               nxt_state = embi_pkg::ST_IDLE;
            end
            else
            begin
               nxt_beat = beat_ff + embi_pkg::BEAT_W'(1);
               nxt_cyc = cyc_load_ff;
               nxt_state = embi_pkg::ST_STROBE;
            end
         end
         embi_pkg::ST_HOLD:
         begin
            nxt_bus_oe = 1'b0;
            nxt_ack_n = hold_n_sync;
            if (hold_n_sync)
            begin
               nxt_state = embi_pkg::ST_IDLE;
            end
         end
         default:
         begin
            nxt_state = embi_pkg::ST_IDLE;
         end
      endcase
   end

   // Pin values follow the next state; one idle cycle separates beats
   always_comb
   begin
      nxt_ready = (nxt_state == embi_pkg::ST_IDLE) && hold_n_sync && ack_n_ff;
      nxt_addr = addr_ff;
      nxt_dout = dout_ff;
      nxt_dout_oe = 1'b0;
      nxt_sel_n = embi_pkg::BANK_NONE_N;
      nxt_wr_n = 1'b1;
      nxt_rd_n = 1'b1;
      nxt_lane_n = embi_pkg::LANES_OFF_N;
      nxt_wbe_n = embi_pkg::LANES_OFF_N;
      if (nxt_state == embi_pkg::ST_STROBE || nxt_state == embi_pkg::ST_WAIT)
      begin
         nxt_addr = beat_addr;
         nxt_sel_n = nxt_hit_sel_n;
         nxt_lane_n = ~beat_lane;
         if (nxt_req.we)
         begin
            nxt_dout = beat_dout;
            nxt_dout_oe = 1'b1;
            nxt_wr_n = 1'b0;
            nxt_wbe_n = ~beat_lane;
         end
         else
         begin
            nxt_rd_n = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_ff <= embi_pkg::ST_IDLE;
         req_ff <= '0;
         wid_ff <= embi_pkg::WID_32;
         cyc_ff <= embi_pkg::CYC_MIN;
         cyc_load_ff <= embi_pkg::CYC_MIN;
         beat_ff <= '0;
         hit_sel_n_ff <= embi_pkg::BANK_NONE_N;
         sel_n_ff <= embi_pkg::BANK_NONE_N;
         addr_ff <= '0;
         dout_ff <= '0;
         rdata_ff <= '0;
         dout_oe_ff <= 1'b0;
         bus_oe_ff <= 1'b1;
         wr_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         lane_n_ff <= embi_pkg::LANES_OFF_N;
         wbe_n_ff <= embi_pkg::LANES_OFF_N;
         ack_n_ff <= 1'b1;
         ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_ff <= '0;
         dclk_ff <= '0;
         dcke_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         req_ff <= nxt_req;
         wid_ff <= nxt_wid;
         cyc_ff <= nxt_cyc;
         cyc_load_ff <= nxt_cyc_load;
         beat_ff <= nxt_beat;
         hit_sel_n_ff <= nxt_hit_sel_n;
         sel_n_ff <= nxt_sel_n;
         addr_ff <= nxt_addr;
         dout_ff <= nxt_dout;
         rdata_ff <= nxt_rdata;
         dout_oe_ff <= nxt_dout_oe;
         bus_oe_ff <= nxt_bus_oe;
         wr_n_ff <= nxt_wr_n;
         rd_n_ff <= nxt_rd_n;
         lane_n_ff <= nxt_lane_n;
         wbe_n_ff <= nxt_wbe_n;
         ack_n_ff <= nxt_ack_n;
         ready_ff <= nxt_ready;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_ff <= nxt_rsp;
         dclk_ff <= nxt_dclk;
         dcke_ff <= nxt_dcke;
      end
   end

   // No command sequencer here, so DRAM strobes and selects stay idle
   logic dram_idle_ff;
   logic nxt_dram_idle;
   always_comb
   begin
      nxt_dram_idle = 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      dram_idle_ff <= nxt_dram_idle;
   end

   assign nand_boot_o = nand_boot_ff;
   assign test_mode_o = test_mode_ff;
   assign req_ready_o = ready_ff;
   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_o = rsp_ff;
   assign addr_o = addr_ff;
   assign data_o = dout_ff;
   assign data_oe_o = dout_oe_ff;
   assign bus_oe_o = bus_oe_ff;
   assign bank_select_n_o = sel_n_ff;
   assign write_strobe_n_o = wr_n_ff;
   assign read_strobe_n_o = rd_n_ff;
   assign byte_lane_enable_n_o = lane_n_ff;
   assign write_byte_enable_n_o = wbe_n_ff;
   assign bus_hold_ack_n_o = ack_n_ff;
   assign dram_row_strobe_n_o = dram_idle_ff;
   assign dram_col_strobe_n_o = dram_idle_ff;
   assign dram_select_n_o = {embi_pkg::DRAM_SEL_W{dram_idle_ff}};
   assign dram_mask_o = lane_n_ff;
   assign dram_clk_o = dclk_ff;
   assign dram_clock_enable_o = dcke_ff;
endmodule : embi_ctrl

// *** test/embi_ctrl_sva.sv ***
`timescale 1ns/1ps
module embi_ctrl_sva (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic nand_boot_o,
   input wire logic test_mode_o,
   input wire logic [embi_pkg::ADDR_W-1:0] addr_o,
   input wire logic data_oe_o,
   input wire logic bus_oe_o,
   input wire logic [embi_pkg::BANKS-1:0] bank_select_n_o,
   input wire logic write_strobe_n_o,
   input wire logic read_strobe_n_o,
   input wire logic [embi_pkg::LANES-1:0] byte_lane_enable_n_o,
   input wire logic [embi_pkg::LANES-1:0] write_byte_enable_n_o,
   input wire logic cycle_extend_n_i,
   input wire logic bus_hold_request_n_i,
   input wire logic bus_hold_ack_n_o,
   input wire logic dram_row_strobe_n_o,
   input wire logic [embi_pkg::LANES-1:0] dram_mask_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic stb;
   assign stb = !write_strobe_n_o || !read_strobe_n_o;
   sequence s_stall;
      (stb && !cycle_extend_n_i) [*4];
   endsequence
   sequence s_return;
      !bus_oe_o ##1 bus_oe_o;
   endsequence
   AST_BOOT_EXCL: assert property (!(nand_boot_o && test_mode_o))
      else $error("boot decode flags both set");
   AST_BOOT_KEPT: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
      && $past(rst_n_i, 3) |-> $stable({nand_boot_o, test_mode_o}))
      else $error("boot decode moved after reset");
   AST_ADDR_HOLD: assert property (stb && $past(stb) |-> $stable(addr_o))
      else $error("address moved within a beat");
   AST_ONE_BANK: assert property (stb |-> $onehot(~bank_select_n_o))
      else $error("strobe without exactly one bank select");
   AST_WRITE: assert property (!write_strobe_n_o |-> data_oe_o && read_strobe_n_o
      && write_byte_enable_n_o == byte_lane_enable_n_o)
      else $error("write strobe without data drive");
   AST_READ: assert property (!read_strobe_n_o |-> !data_oe_o
      && write_byte_enable_n_o == 4'hF)
      else $error("read strobe with data drive or write lanes");
   AST_HOLD_REQ: assert property (!bus_hold_ack_n_o |-> !$past(bus_hold_request_n_i, 3))
      else $error("acknowledge without request");
   AST_HOLD_ORDER: assert property ($fell(bus_hold_ack_n_o) |-> $past(!bus_oe_o))
      else $error("acknowledge before pins released");
   AST_HOLD_FREE: assert property (!bus_hold_ack_n_o |-> !bus_oe_o && !data_oe_o && !stb)
      else $error("device active during hold");
   AST_HOLD_BACK: assert property ($rose(bus_hold_ack_n_o) |-> s_return)
      else $error("pins not retaken after hold");
   AST_WAIT: assert property (s_stall |=> stb)
      else $error("cycle ended while wait low");
   AST_DRAM: assert property (dram_mask_o == byte_lane_enable_n_o && dram_row_strobe_n_o)
      else $error("dram mask or row strobe wrong");
endmodule : embi_ctrl_sva

bind embi_ctrl embi_ctrl_sva u_sva (.sys_clk_i, .rst_n_i, .nand_boot_o, .test_mode_o,
   .addr_o, .data_oe_o, .bus_oe_o, .bank_select_n_o, .write_strobe_n_o, .read_strobe_n_o,
   .byte_lane_enable_n_o, .write_byte_enable_n_o, .cycle_extend_n_i, .bus_hold_request_n_i,
   .bus_hold_ack_n_o, .dram_row_strobe_n_o, .dram_mask_o);

// *** test/embi_mem_model.sv ***
`timescale 1ns/1ps
module embi_mem_model (
   input wire logic sys_clk_i,
   input wire logic [26:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic data_oe_i,
   input wire logic [7:0] sel_n_i,
   input wire logic wr_n_i,
   input wire logic rd_n_i,
   input wire logic [3:0] wbe_n_i,
   input wire logic [7:0] wait_len_i,
   output logic [31:0] rdata_o,
   output logic wait_n_o,
   output int beats_o
);
   logic [7:0] mem [0:4095];
   logic [31:0] pat_ff = 32'h5A5A_5A5A;
   logic [7:0] cnt_ff = 8'h00;
   logic stb_ff = 1'b0;
   int beats_ff = 0;
   logic sel;
   assign sel = sel_n_i != 8'hFF;
   assign beats_o = beats_ff;
   // Pull-up idles high; low only while a beat is stretched
   assign wait_n_o = cnt_ff == 8'h00;
   // Released bus shows a changing pattern, never the last value
   always_comb
   begin
      rdata_o = pat_ff;
      if (data_oe_i)
         rdata_o = wdata_i;
      else if (!rd_n_i && sel)
         for (int k = 0; k < 4; k++)
            rdata_o[8*k+:8] = mem[addr_i[11:0] + 12'(k)];
   end
   always @(posedge sys_clk_i)
   begin
      pat_ff <= ~pat_ff;
      stb_ff <= sel && (!wr_n_i || !rd_n_i);
      if (sel && (!wr_n_i || !rd_n_i) && !stb_ff)
      begin
         beats_ff <= beats_ff + 1;
         cnt_ff <= wait_len_i;
      end
      else if (cnt_ff != 8'h00)
         cnt_ff <= cnt_ff - 8'h01;
      if (sel && !wr_n_i)
         for (int k = 0; k < 4; k++)
            if (!wbe_n_i[k])
               mem[addr_i[11:0] + 12'(k)] <= wdata_i[8*k+:8];
   end
endmodule : embi_mem_model

// *** test/tb_embi_ctrl.sv ***
`timescale 1ns/1ps
module tb_embi_ctrl;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] boot_mode_pins_i = 2'h1;
   logic [31:0] bank_cycles_i = 32'h4444_4444;
   logic [15:0] bank_width_i = 16'hAA18;
   logic [23:0] bank_size_i = 24'h00_0000;
   logic req_valid_i = 1'b0;
   embi_pkg::embi_req_s req_i = '0;
   logic bus_hold_request_n_i = 1'b1;
   logic [7:0] wlen = 8'h00;
   logic req_ready_o, rsp_valid_o, nand_boot_o, test_mode_o, data_oe_o, bus_oe_o;
   logic write_strobe_n_o, read_strobe_n_o, cycle_extend_n_i, bus_hold_ack_n_o;
   logic dram_row_strobe_n_o, dram_col_strobe_n_o, dram_clock_enable_o;
   embi_pkg::embi_rsp_s rsp_o;
   logic [26:0] addr_o;
   logic [31:0] data_o, data_i;
   logic [7:0] bank_select_n_o;
   logic [3:0] byte_lane_enable_n_o, write_byte_enable_n_o, dram_mask_o;
   logic [1:0] dram_select_n_o, dram_clk_o;
   int beats;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #20 sys_clk_i = ~sys_clk_i;

   embi_ctrl dut (.sys_clk_i, .rst_n_i, .boot_mode_pins_i, .bank_cycles_i, .bank_width_i,
      .bank_size_i, .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_o, .nand_boot_o,
      .test_mode_o, .addr_o, .data_o, .data_oe_o, .data_i, .bus_oe_o, .bank_select_n_o,
      .write_strobe_n_o, .read_strobe_n_o, .byte_lane_enable_n_o, .write_byte_enable_n_o,
      .cycle_extend_n_i, .bus_hold_request_n_i, .bus_hold_ack_n_o, .dram_row_strobe_n_o,
      .dram_col_strobe_n_o, .dram_select_n_o, .dram_mask_o, .dram_clk_o,
      .dram_clock_enable_o);

   embi_mem_model u_mem (.sys_clk_i, .addr_i(addr_o), .wdata_i(data_o), .data_oe_i(data_oe_o),
      .sel_n_i(bank_select_n_o), .wr_n_i(write_strobe_n_o), .rd_n_i(read_strobe_n_o),
      .wbe_n_i(write_byte_enable_n_o), .wait_len_i(wlen), .rdata_o(data_i),
      .wait_n_o(cycle_extend_n_i), .beats_o(beats));

   task automatic results;
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic do_reset(input logic [1:0] code);
      rst_n_i <= 1'b0;
      boot_mode_pins_i <= code;
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      @(posedge sys_clk_i);
   endtask : do_reset

   task automatic xfer(input logic we, input logic [2:0] bk, input logic [26:0] off,
      input logic [31:0] wd, input logic [3:0] be, output embi_pkg::embi_rsp_s r,
      output int lat, output int nb);
      int n;
      int b0;
      b0 = beats;
      n = 0;
      req_i <= '{we, {bk, off}, wd, be};
      req_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      while (req_ready_o !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      req_valid_i <= 1'b0;
      lat = 0;
      while (rsp_valid_o !== 1'b1 && lat < 400)
      begin
         @(posedge sys_clk_i);
         lat++;
      end
      r = rsp_o;
      nb = beats - b0;
   endtask : xfer

   task automatic t_boot;
      embi_pkg::embi_rsp_s r;
      int lat;
      int nb;
      for (int c = 0; c < 4; c++)
      begin
         do_reset(c[1:0]);
         boot_mode_pins_i <= ~c[1:0];
         repeat (3) @(posedge sys_clk_i);
         chk(nand_boot_o, c == 0, "nand boot");
         chk(test_mode_o, c == 3, "test mode");
         xfer(1'b1, 3'h0, 27'h0, 32'h1122_3344, 4'hF, r, lat, nb);
         chk(nb, (c == 2) ? 1 : 2, "bank0 beats");
      end
      do_reset(2'h2);
   endtask : t_boot

   task automatic t_rw;
      embi_pkg::embi_rsp_s r;
      int lat;
      int nb;
      // Banks 1..3 are 32, 16 and 8 bits wide
      for (int b = 1; b < 4; b++)
      begin
         xfer(1'b1, b[2:0], 27'(b * 64), 32'hA5C3_1E77 ^ b, 4'hF, r, lat, nb);
         chk(nb, 1 << (b - 1), "write beats");
         chk(r.err, 0, "write err");
         chk(u_mem.mem[b * 64], 8'h77 ^ b, "byte at address");
         xfer(1'b0, b[2:0], 27'(b * 64), 32'h0, 4'hF, r, lat, nb);
         chk(r.rdata, 32'hA5C3_1E77 ^ b, "read data");
         chk(nb, 1 << (b - 1), "read beats");
      end
      xfer(1'b1, 3'h1, 27'h40, 32'hFFFF_FFFF, 4'h2, r, lat, nb);
      chk(u_mem.mem[65], 8'hFF, "enabled lane written");
      chk(u_mem.mem[66], 8'hC3, "masked lane kept");
   endtask : t_rw

   task automatic t_wait;
      embi_pkg::embi_rsp_s r;
      int lat0;
      int lat1;
      int nb;
      xfer(1'b0, 3'h1, 27'h40, 32'h0, 4'hF, r, lat0, nb);
      wlen <= 8'h0A;
      xfer(1'b0, 3'h1, 27'h40, 32'h0, 4'hF, r, lat1, nb);
      wlen <= 8'h00;
      chk(lat1 >= lat0 + 6, 1, "wait stretch");
      chk(r.rdata, 32'hA5C3_FF76, "read after wait");
   endtask : t_wait

   task automatic t_region;
      embi_pkg::embi_rsp_s r;
      int lat;
      int lat2;
      int nb;
      xfer(1'b1, 3'h4, 27'h10_0000, 32'h0, 4'hF, r, lat, nb);
      chk(r.err, 1, "out of region err");
      chk(lat, 1, "err latency");
      chk(nb, 0, "no pin activity");
      xfer(1'b1, 3'h4, 27'h0F_FFFC, 32'h0, 4'hF, r, lat, nb);
      chk(r.err, 0, "last word in region");
      chk(nb, 1, "last word beats");
      // Doubled region and a zero strobe count on bank 4
      bank_size_i <= 24'h00_1000;
      bank_cycles_i <= 32'h4440_4444;
      xfer(1'b1, 3'h4, 27'h10_0000, 32'h0, 4'hF, r, lat2, nb);
      chk(r.err, 0, "doubled region");
      chk(lat - lat2, 3, "zero count acts as one");
      bank_size_i <= 24'h00_0000;
      bank_cycles_i <= 32'h4444_4444;
   endtask : t_region

   task automatic t_hold;
      int n;
      n = 0;
      bus_hold_request_n_i <= 1'b0;
      // Other master keeps off the shared pins until acknowledged
      while (bus_hold_ack_n_o !== 1'b0 && n < 20)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(n <= 6, 1, "ack delay");
      repeat (3) @(posedge sys_clk_i);
      chk(bus_oe_o, 0, "pins released");
      chk(req_ready_o, 0, "refused in hold");
      bus_hold_request_n_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      chk({bus_hold_ack_n_o, bus_oe_o, req_ready_o}, 3'h7, "bus retaken");
   endtask : t_hold

   task automatic t_dram;
      logic [1:0] v;
      chk({dram_row_strobe_n_o, dram_col_strobe_n_o, dram_select_n_o, dram_clock_enable_o},
         5'h1F, "dram idle");
      v = dram_clk_o;
      @(posedge sys_clk_i);
      // Xor keeps the compare at two bits
      chk(dram_clk_o ^ v, 2'h3, "dram clock toggles");
   endtask : t_dram

   initial
   begin
      do_reset(2'h1);
      t_boot();
      t_rw();
      t_wait();
      t_region();
      t_hold();
      t_dram();
      results();
   end
endmodule : tb_embi_ctrl
